// *** tdc_map.svh ***
`ifndef TDC_MAP_SVH
`define TDC_MAP_SVH
// Function
// - Memory test failure reports failing address
// - Block length error reports requested minus actual
// - Data mismatch returns expected and actual bytes
// - Drive status byte 1 bit layout
// - Drive status byte 2 bit layout
// - Send diagnostic opcode, self and unit flags
// - Self test runs memory test only
// - Self test good, else hardware error
// - Unit test fetches parameters, runs tests 1-5
// - Both flags zero: no test, good status
// - Pass counts order tests, zero skips test
// - Any test error stops with check condition
// - Test 1: rewind, file mark, erase, blank
// - Test 2: 256 8K blocks, read both ways
// - Test 3: growing 16-byte steps to 8K
// - Test 4: buffer pattern, 128-byte blocks, four times
// - Test 5 length, data, increment from parameters
// - Test 5 writes to end, reads unchecked
// - Write buffer opcode and descriptor fields
// - Write buffer mode 0 header, 2 data
// - Result byte 0 holds error number
// - At most nine result bytes returned

// Register byte addresses
`define TDC_A_CDB0      8'h00
`define TDC_A_CDB1      8'h04
`define TDC_A_CDB2      8'h08
`define TDC_A_PRM0      8'h0c
`define TDC_A_PRM1      8'h10
`define TDC_A_PRM2      8'h14
`define TDC_A_CTRL      8'h18
`define TDC_A_STATUS    8'h1c
`define TDC_A_RES0      8'h20
`define TDC_A_RES1      8'h24
`define TDC_A_RES2      8'h28
`define TDC_A_ALLOC     8'h2c

// Control and status bit positions
`define TDC_CTRL_START  0
`define TDC_CTRL_PRMOK  1
`define TDC_ST_BUSY     0
`define TDC_ST_PRMWANT  1
`define TDC_ST_DONE     2
`define TDC_ST_WBDATA   3

// Command descriptor fields
`define TDC_OPC_SENDDIAG 8'h1d
`define TDC_OPC_WRBUF    8'h3b
`define TDC_SD_SELF_TEST_SELECT     2
`define TDC_SD_UNIT      0
`define TDC_WB_MODE_HDR  2'h0
`define TDC_WB_MODE_DATA 2'h2

// Status and sense values
`define TDC_SCSI_GOOD    8'h00
`define TDC_SCSI_CHECK   8'h02
`define TDC_SENSE_NONE   4'h0
`define TDC_SENSE_HWERR  4'h4
`define TDC_SENSE_ILLREQ 4'h5
`define TDC_ERR_BLKLEN   8'h85

// Result and parameter sizes
`define TDC_RES_BYTES    9
`define TDC_PRM_BYTES    9
`define TDC_RES_MAX      16'h0009
`define TDC_LAST_TEST    3'd5

// Test geometry
`define TDC_BLK_8K       16'h2000
`define TDC_T2_BLOCKS    16'h0100
`define TDC_T3_STEP      16'h0010
`define TDC_T3_BLOCKS    (`TDC_BLK_8K / `TDC_T3_STEP)
`define TDC_T4_BLK       16'h0080
`define TDC_T4_REPS      16'h0004

`endif

// *** tdc_pkg.sv ***
package tdc_pkg;

    typedef enum logic [3:0] {
        OP_MEMTEST  = 4'h0,
        OP_REWIND   = 4'h1,
        OP_WFM      = 4'h2,
        OP_ERASE    = 4'h3,
        OP_BLANK    = 4'h4,
        OP_WRITE    = 4'h5,
        OP_READ     = 4'h6,
        OP_READ_REV = 4'h7,
        OP_BUF_FILL = 4'h8,
        OP_BUF_WR   = 4'h9,
        OP_BUF_RD   = 4'ha
    } tdc_op_code_t;

    typedef struct packed {
        tdc_op_code_t code;
        logic [15:0]  length;
        logic [7:0]   data;
        logic [7:0]   incr;
        logic         check;
        logic         high_speed;
    } tdc_op_t;

    typedef struct packed {
        logic         err;
        logic [7:0]   code;
        logic [23:0]  addr;
        logic [15:0]  act_len;
        logic [7:0]   expected;
        logic [7:0]   actual;
        logic         eot;
    } tdc_resp_t;

    typedef struct packed {
        logic formatter_busy;
        logic data_busy;
        logic check_char_gate;
        logic end_of_tape;
        logic ready;
        logic rewinding;
        logic file_protect;
        logic online;
    } tdc_stat1_t;

    typedef struct packed {
        logic parity_error;
        logic file_mark;
        logic buffer_overflow;
        logic high_speed;
        logic nrzi;
        logic beginning_of_tape;
        logic formatter_busy_interrupt;
        logic data_busy_interrupt;
    } tdc_stat2_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_DECODE = 3'b001,
        ST_PARAM  = 3'b010,
        ST_NEXT   = 3'b011,
        ST_ISSUE  = 3'b100,
        ST_WAIT   = 3'b101,
        ST_FINISH = 3'b110
    } tdc_state_t;

endpackage : tdc_pkg

// *** tdc_op_port.sv ***
`timescale 1ns/1ns
module tdc_op_port (
    // Clock, reset, enable
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              ce,
    // Sequencer side
    input  wire logic              issue,
    input  tdc_pkg::tdc_op_t       next_op,
    output logic                   fin,
    output tdc_pkg::tdc_resp_t     resp,
    // Operation channel
    output logic                   op_valid,
    output tdc_pkg::tdc_op_t       op,
    input  wire logic              op_ready,
    input  wire logic              op_done,
    input  tdc_pkg::tdc_resp_t     op_resp
);

    logic waiting;

    // Request held until taken, answer awaited only after that
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_valid <= 1'b0;
            op       <= '0;
            waiting  <= 1'b0;
            fin      <= 1'b0;
            resp     <= '0;
        end else if (ce) begin
            fin <= 1'b0;
            if (issue) begin
                op_valid <= 1'b1;
                op       <= next_op;
            end else if (op_valid && op_ready) begin
                op_valid <= 1'b0;
                waiting  <= 1'b1;
            end
            if (waiting && op_done) begin
                waiting <= 1'b0;
                fin     <= 1'b1;
                resp    <= op_resp;
            end
        end
    end

endmodule : tdc_op_port

// *** tdc_handler.sv ***
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "tdc_map.svh"
module tdc_handler (
    // Clock, reset, enable
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              ce,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // Drive status
    input  tdc_pkg::tdc_stat1_t    drive_stat1,
    input  tdc_pkg::tdc_stat2_t    drive_stat2,
    // Tape and memory operation channel
    output logic                   op_valid,
    output tdc_pkg::tdc_op_t       op,
    input  wire logic              op_ready,
    input  wire logic              op_done,
    input  tdc_pkg::tdc_resp_t     op_resp
);

    tdc_pkg::tdc_state_t  state;
    tdc_pkg::tdc_op_t     plan_op;
    tdc_pkg::tdc_resp_t   resp;

    logic [9:0][7:0]  cdb;
    logic [8:0][7:0]  prm;
    logic [8:0][7:0]  prm_eff;
    logic [8:0][7:0]  res;
    logic [15:0]      alloc_len;
    logic [15:0]      res_cnt;
    logic [7:0]       scsi_status;
    logic [3:0]       sense_key;
    logic             done;
    logic             wb_data_mode;
    logic [2:0]       test_idx;
    logic [1:0]       phase;
    logic [15:0]      blk;
    logic [7:0]       pass_left;
    logic [15:0]      t5_blocks;
    logic [15:0]      plen;
    logic [15:0]      plan_reps;
    logic             plan_last;
    logic             plan_eot;
    logic             busy;
    logic             acc;
    logic             wr_pend;
    logic [7:0]       wr_addr;
    logic [31:0]      rd_mux;
    logic             start_p;
    logic             prm_ok_p;
    logic             fin;
    logic             issue;
    logic             more;
    logic             ev_fail;
    logic [7:0]       cur_pass;
    logic [15:0]      t3_len;
    logic [15:0]      len_diff;

    // AHB-Lite slave: zero-wait, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign acc       = hsel && htrans[1] && hready;
    assign busy      = (state != tdc_pkg::ST_IDLE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata  <= 32'h0000_0000;
        end else if (ce) begin
            wr_pend <= acc && hwrite;
            if (acc) begin
                wr_addr <= haddr[7:0];
            end
            if (acc && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    assign start_p  = ce && wr_pend && (wr_addr == `TDC_A_CTRL)
                      && hwdata[`TDC_CTRL_START] && !busy;
    assign prm_ok_p = ce && wr_pend && (wr_addr == `TDC_A_CTRL)
                      && hwdata[`TDC_CTRL_PRMOK];

    // Descriptor locked while busy so the sequencer sees one command
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cdb       <= '0;
            prm       <= '0;
            alloc_len <= 16'h0000;
        end else if (ce && wr_pend) begin
            case (wr_addr)
                `TDC_A_CDB0: if (!busy) cdb[3:0] <= hwdata;
                `TDC_A_CDB1: if (!busy) cdb[7:4] <= hwdata;
                `TDC_A_CDB2: if (!busy) cdb[9:8] <= hwdata[15:0];
                `TDC_A_PRM0: prm[3:0] <= hwdata;
                `TDC_A_PRM1: prm[7:4] <= hwdata;
                `TDC_A_PRM2: prm[8]   <= hwdata[7:0];
                `TDC_A_ALLOC: alloc_len <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    // Never more than nine result bytes handed back
    assign res_cnt = (alloc_len > `TDC_RES_MAX) ? `TDC_RES_MAX
                                                : alloc_len;

    always_comb begin
        case (haddr[7:0])
            `TDC_A_CDB0:   rd_mux = cdb[3:0];
            `TDC_A_CDB1:   rd_mux = cdb[7:4];
            `TDC_A_CDB2:   rd_mux = {16'h0000, cdb[9:8]};
            `TDC_A_PRM0:   rd_mux = prm[3:0];
            `TDC_A_PRM1:   rd_mux = prm[7:4];
            `TDC_A_PRM2:   rd_mux = {24'h000000, prm[8]};
            `TDC_A_STATUS: rd_mux = {5'h00, test_idx, 4'h0, sense_key,
                                     scsi_status, 4'h0, wb_data_mode,
                                     done, state == tdc_pkg::ST_PARAM,
                                     busy};
            `TDC_A_RES0:   rd_mux = res[3:0];
            `TDC_A_RES1:   rd_mux = res[7:4];
            `TDC_A_RES2:   rd_mux = {24'h000000, res[8]};
            `TDC_A_ALLOC:  rd_mux = {res_cnt, alloc_len};
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    // Parameter bytes beyond the announced list length count as zero
    assign plen = {cdb[3], cdb[4]};
    genvar gi;
    for (gi = 0; gi < `TDC_PRM_BYTES; gi++) begin : g_prm
        assign prm_eff[gi] = (16'(gi) < plen) ? prm[gi] : 8'h00;
    end

    assign cur_pass = prm_eff[4'(test_idx - 3'd1)];
    assign t3_len   = 16'({blk[11:0], 4'h0} + `TDC_T3_STEP);

    // Operation plan for the current test, phase and block
    always_comb begin
        plan_op            = '0;
        plan_op.check      = (test_idx != `TDC_LAST_TEST);
        plan_op.high_speed = 1'b0;
        plan_reps          = 16'h0001;
        plan_last          = 1'b0;
        plan_eot           = 1'b0;
        case (test_idx)
            3'd0: begin
                plan_op.code = tdc_pkg::OP_MEMTEST;
                plan_last    = 1'b1;
            end
            3'd1: begin
                case (phase)
                    2'd0: plan_op.code = tdc_pkg::OP_REWIND;
                    2'd1: plan_op.code = tdc_pkg::OP_WFM;
                    2'd2: plan_op.code = tdc_pkg::OP_ERASE;
                    default: begin
                        plan_op.code = tdc_pkg::OP_BLANK;
                        plan_last    = 1'b1;
                    end
                endcase
            end
            3'd2: begin
                plan_op.length = `TDC_BLK_8K;
                plan_reps      = `TDC_T2_BLOCKS;
                case (phase)
                    2'd0: plan_op.code = tdc_pkg::OP_WRITE;
                    2'd1: begin
                        plan_op.code = tdc_pkg::OP_REWIND;
                        plan_reps    = 16'h0001;
                    end
                    2'd2: plan_op.code = tdc_pkg::OP_READ;
                    default: begin
                        plan_op.code = tdc_pkg::OP_READ_REV;
                        plan_last    = 1'b1;
                    end
                endcase
            end
            3'd3: begin
                plan_op.length = t3_len;
                plan_reps      = `TDC_T3_BLOCKS;
                case (phase)
                    2'd0: plan_op.code = tdc_pkg::OP_WRITE;
                    2'd1: begin
                        plan_op.code = tdc_pkg::OP_REWIND;
                        plan_reps    = 16'h0001;
                    end
                    default: begin
                        plan_op.code = tdc_pkg::OP_READ;
                        plan_last    = 1'b1;
                    end
                endcase
            end
            3'd4: begin
                case (phase)
                    2'd0: plan_op.code = tdc_pkg::OP_BUF_FILL;
                    2'd1: begin
                        plan_op.code       = tdc_pkg::OP_BUF_WR;
                        plan_op.length     = `TDC_T4_BLK;
                        plan_op.high_speed = 1'b1;
                        plan_reps          = `TDC_T4_REPS;
                    end
                    2'd2: plan_op.code = tdc_pkg::OP_REWIND;
                    default: begin
                        plan_op.code = tdc_pkg::OP_BUF_RD;
                        plan_reps    = `TDC_T4_REPS;
                        plan_last    = 1'b1;
                    end
                endcase
            end
            default: begin
                plan_op.length = {prm_eff[5], prm_eff[6]};
                plan_op.data   = prm_eff[7];
                plan_op.incr   = prm_eff[8];
                case (phase)
                    2'd0: begin
                        plan_op.code = tdc_pkg::OP_WRITE;
                        plan_eot     = 1'b1;
                    end
                    2'd1: plan_op.code = tdc_pkg::OP_REWIND;
                    default: begin
                        plan_op.code = tdc_pkg::OP_READ;
                        plan_reps    = t5_blocks;
                        plan_last    = 1'b1;
                    end
                endcase
            end
        endcase
    end

    assign more    = plan_eot ? !resp.eot
                              : (16'(blk + 16'h0001) < plan_reps);
    assign ev_fail = (state == tdc_pkg::ST_WAIT) && fin && resp.err;
    assign issue   = ce && (state == tdc_pkg::ST_ISSUE);

    // Command sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state        <= tdc_pkg::ST_IDLE;
            test_idx     <= 3'd0;
            phase        <= 2'd0;
            blk          <= 16'h0000;
            pass_left    <= 8'h00;
            t5_blocks    <= 16'h0001;
            scsi_status  <= `TDC_SCSI_GOOD;
            sense_key    <= `TDC_SENSE_NONE;
            done         <= 1'b0;
            wb_data_mode <= 1'b0;
        end else if (ce) begin
            case (state)
                tdc_pkg::ST_IDLE: begin
                    if (start_p) begin
                        done        <= 1'b0;
                        scsi_status <= `TDC_SCSI_GOOD;
                        sense_key   <= `TDC_SENSE_NONE;
                        state       <= tdc_pkg::ST_DECODE;
                    end
                end
                tdc_pkg::ST_DECODE: begin
                    phase <= 2'd0;
                    blk   <= 16'h0000;
                    state <= tdc_pkg::ST_FINISH;
                    if (cdb[0] == `TDC_OPC_SENDDIAG) begin
                        if (cdb[1][`TDC_SD_SELF_TEST_SELECT]) begin
                            test_idx <= 3'd0;
                            state    <= tdc_pkg::ST_ISSUE;
                        end else if (cdb[1][`TDC_SD_UNIT]) begin
                            test_idx <= 3'd1;
                            state    <= tdc_pkg::ST_PARAM;
                        end
                        // Neither flag: straight to good status
                    end else if (cdb[0] == `TDC_OPC_WRBUF) begin
                        case (cdb[1][1:0])
                            `TDC_WB_MODE_HDR:  wb_data_mode <= 1'b0;
                            `TDC_WB_MODE_DATA: wb_data_mode <= 1'b1;
                            default: begin
                                scsi_status <= `TDC_SCSI_CHECK;
                                sense_key   <= `TDC_SENSE_ILLREQ;
                            end
                        endcase
                    end else begin
                        scsi_status <= `TDC_SCSI_CHECK;
                        sense_key   <= `TDC_SENSE_ILLREQ;
                    end
                end
                tdc_pkg::ST_PARAM: begin
                    if (prm_ok_p) begin
                        state <= tdc_pkg::ST_NEXT;
                    end
                end
                tdc_pkg::ST_NEXT: begin
                    phase <= 2'd0;
                    blk   <= 16'h0000;
                    if (test_idx > `TDC_LAST_TEST) begin
                        state <= tdc_pkg::ST_FINISH;
                    end else if (cur_pass == 8'h00) begin
                        test_idx <= 3'(test_idx + 3'd1);
                    end else begin
                        pass_left <= cur_pass;
                        state     <= tdc_pkg::ST_ISSUE;
                    end
                end
                tdc_pkg::ST_ISSUE: begin
                    state <= tdc_pkg::ST_WAIT;
                end
                tdc_pkg::ST_WAIT: begin
                    if (fin) begin
                        state <= tdc_pkg::ST_ISSUE;
                        if (resp.err) begin
                            scsi_status <= `TDC_SCSI_CHECK;
                            sense_key   <= `TDC_SENSE_HWERR;
                            state       <= tdc_pkg::ST_FINISH;
                        end else if (more) begin
                            blk <= 16'(blk + 16'h0001);
                        end else begin
                            blk <= 16'h0000;
                            if (plan_eot) begin
                                t5_blocks <= 16'(blk + 16'h0001);
                            end
                            if (!plan_last) begin
                                phase <= 2'(phase + 2'd1);
                            end else if (test_idx == 3'd0) begin
                                state <= tdc_pkg::ST_FINISH;
                            end else begin
                                phase     <= 2'd0;
                                pass_left <= 8'(pass_left - 8'h01);
                                if (pass_left == 8'h01) begin
                                    test_idx <= 3'(test_idx + 3'd1);
                                    state    <= tdc_pkg::ST_NEXT;
                                end
                            end
                        end
                    end
                end
                tdc_pkg::ST_FINISH: begin
                    done  <= 1'b1;
                    state <= tdc_pkg::ST_IDLE;
                end
                default: state <= tdc_pkg::ST_IDLE;
            endcase
        end
    end

    // Block length error carries requested minus actual size
    assign len_diff = 16'(plan_op.length - resp.act_len);

    // Diagnostic result bytes, cleared at each new command
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            res <= '0;
        end else if (ce) begin
            if (start_p) begin
                res <= '0;
            end else if (ev_fail) begin
                res[0] <= resp.code;
                res[1] <= {5'h00, test_idx};
                if (resp.code == `TDC_ERR_BLKLEN) begin
                    {res[2], res[3], res[4]} <= {8'h00, len_diff};
                end else begin
                    {res[2], res[3], res[4]} <= resp.addr;
                end
                res[5] <= resp.expected;
                res[6] <= resp.actual;
            end else if (state == tdc_pkg::ST_FINISH) begin
                res[7] <= drive_stat1;
                res[8] <= drive_stat2;
            end
        end
    end

    tdc_op_port u_port (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .ce       (ce),
        .issue    (issue),
        .next_op  (plan_op),
        .fin      (fin),
        .resp     (resp),
        .op_valid (op_valid),
        .op       (op),
        .op_ready (op_ready),
        .op_done  (op_done),
        .op_resp  (op_resp)
    );

endmodule : tdc_handler

// *** tdc_chk.sv ***
`timescale 1ns/1ns
module tdc_chk (
    // Bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // Operations
    input wire logic        op_valid,
    input tdc_pkg::tdc_op_t op,
    input wire logic        op_ready,
    input wire logic        op_done
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire rd = hsel && htrans[1] && !hwrite;
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus stalled or not okay");
    a_unmapped_zero: assert property (rd && haddr[7:0] == 8'h30
        |=> hrdata == 32'h0) else $error("unmapped read not zero");
    a_alloc_cap: assert property (rd && haddr[7:0] == 8'h2c
        |=> hrdata[31:16] <= 16'h0009) else $error("result count above 9");
    a_op_hold: assert property (op_valid && !op_ready
        |=> op_valid && $stable(op)) else $error("operation not held");
    a_op_drop: assert property (op_valid && op_ready
        |=> !op_valid [*2]) else $error("operation issued too soon");
    a_next_gap: assert property (op_done && !op_valid |=> !op_valid)
        else $error("next operation before gap");
    a_rev_len: assert property (op_valid
        && op.code == tdc_pkg::OP_READ_REV |-> op.length == 16'h2000)
        else $error("reverse read length wrong");
    a_bufwr_fast: assert property (op_valid
        && op.code == tdc_pkg::OP_BUF_WR
        |-> op.length == 16'h0080 && op.high_speed)
        else $error("buffer write block wrong");
endmodule : tdc_chk

bind tdc_handler tdc_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hreadyout, .hresp, .hrdata, .op_valid, .op, .op_ready,
    .op_done);

// *** tdc_op_model.sv ***
`timescale 1ns/1ns
module tdc_op_model (
    // Clock and reset
    input wire logic           hclk,
    input wire logic           hresetn,
    // Operation channel
    input wire logic           op_valid,
    input tdc_pkg::tdc_op_t    op,
    output logic               op_ready,
    output logic               op_done,
    output tdc_pkg::tdc_resp_t op_resp,
    // Scenario controls
    input wire logic [3:0]     fail_code,
    input wire logic [15:0]    eot_after,
    input wire logic           slow
);
    tdc_pkg::tdc_op_t cur;
    logic [15:0]      n_wr = '0;
    initial begin
        op_ready = 0;
        op_done = 0;
        op_resp = '0;
    end
    always begin
        @(posedge hclk);
        if (hresetn && op_valid) begin
            repeat (slow ? 2 : 0) @(posedge hclk);
            op_ready <= 1;
            cur = op;
            @(posedge hclk);
            op_ready <= 0;
            repeat (slow ? 3 : 0) @(posedge hclk);
            n_wr = (cur.code == tdc_pkg::OP_REWIND) ? 16'h0 :
                n_wr + 16'(cur.code == tdc_pkg::OP_WRITE);
            op_resp <= {cur.code == fail_code, 4'h8, cur.code, 24'h012345,
                16'h0123,
                8'h5a, 8'ha5, n_wr >= eot_after};
            op_done <= 1;
            @(posedge hclk);
            op_done <= 0;
            // Stale answer is scrambled so nothing leans on it
            op_resp <= ~op_resp;
        end
    end
endmodule : tdc_op_model

// *** tdc_tb.sv ***
`timescale 1ns/1ns
`include "tdc_map.svh"
module testbench;
    logic               hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic               hready, hreadyout, hresp, op_valid;
    logic               op_ready, op_done, slow = 0;
    logic [31:0]        haddr = '0, hwdata = '0, hrdata, q;
    logic [1:0]         htrans = '0;
    logic [2:0]         hsize = 3'h2;
    logic [3:0]         fail_code = 4'hf;
    logic [15:0]        eot_after = 16'd300;
    tdc_pkg::tdc_op_t   op, last_wr;
    tdc_pkg::tdc_resp_t op_resp;
    int                 errors = 0, tests_run = 0, n_ops = 0, n_rev = 0;
    assign hready = hreadyout;
    tdc_handler DUT (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
        .drive_stat1(8'h96), .drive_stat2(8'h69), .op_valid, .op,
        .op_ready, .op_done, .op_resp);
    tdc_op_model u_far (.hclk, .hresetn, .op_valid, .op, .op_ready,
        .op_done, .op_resp, .fail_code, .eot_after, .slow);
    initial forever #2 hclk = ~hclk;
    always @(posedge hclk) begin
        if (op_valid === 1'b1 && op_ready === 1'b1) begin
            n_ops++;
            n_rev += int'(op.code === tdc_pkg::OP_READ_REV);
            if (op.code === tdc_pkg::OP_WRITE) last_wr = op;
        end
    end
    task automatic stop_test;
        $display("errors %0d checks %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [63:0] e, g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rdy;
        int n;
        @(posedge hclk);
        for (n = 0; hready !== 1'b1; n++) begin
            if (n > 50) begin
                errors++;
                stop_test();
            end
            @(posedge hclk);
        end
    endtask : rdy
    task automatic bus(input logic w, input logic [7:0] a, input [31:0] d);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        rdy();
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        q = hrdata;
    endtask : bus
    task automatic wait_st(input int b);
        for (int n = 0; n < 9000; n++) begin
            bus(0, `TDC_A_STATUS, 0);
            if (q[b] === 1'b1) return;
        end
        errors++;
        stop_test();
    endtask : wait_st
    task automatic cmd(input [31:0] c0, p0, p1, p2);
        n_ops = 0;
        bus(1, `TDC_A_CDB0, c0);
        bus(1, `TDC_A_CDB1, 32'h9);
        bus(1, `TDC_A_CTRL, 1);
        if (c0[15:0] == 16'h011d) begin
            wait_st(1);
            bus(1, `TDC_A_PRM0, p0);
            bus(1, `TDC_A_PRM1, p1);
            bus(1, `TDC_A_PRM2, p2);
            bus(1, `TDC_A_CTRL, 2);
        end
        wait_st(2);
    endtask : cmd
    task automatic sc_misc;
        cmd(32'h1d, 0, 0, 0);
        chk("idle status", 0, q[19:8]);
        chk("idle ops", 0, n_ops);
        bus(1, `TDC_A_ALLOC, 32'h20);
        bus(0, `TDC_A_ALLOC, 0);
        chk("alloc", 32'h00090020, q);
        bus(0, 8'h30, 0);
        chk("unmapped", 0, q);
        for (int i = 0; i < 4; i++) begin
            cmd({22'h0, i[1:0], 8'h3b}, 0, 0, 0);
            chk("wrbuf status", {i[0] ? 12'h502 : 12'h0, i[1]},
                {q[19:8], q[3]});
            chk("wrbuf ops", 0, n_ops);
        end
    endtask : sc_misc
    task automatic sc_self;
        slow <= 1;
        cmd(32'h51d, 0, 0, 0);
        chk("self ok", 1, {q[19:8], 8'(n_ops)});
        fail_code <= tdc_pkg::OP_MEMTEST;
        cmd(32'h41d, 0, 0, 0);
        chk("self bad", 12'h402, q[19:8]);
        bus(0, `TDC_A_RES0, 0);
        chk("res0", 32'h23010080, q);
        bus(0, `TDC_A_RES1, 0);
        chk("res1", 32'h96a55a45, q);
        bus(0, `TDC_A_RES2, 0);
        chk("res2", 32'h69, q);
    endtask : sc_self
    task automatic sc_unit;
        slow <= 0;
        fail_code <= tdc_pkg::OP_WRITE;
        cmd(32'h11d, 32'h101, 0, 0);
        bus(0, `TDC_A_RES0, 0);
        chk("stop", {32'h1e000285, 32'h5}, {q, 32'(n_ops)});
        fail_code <= 4'hf;
        cmd(32'h11d, 32'h01000101, 32'hff800001, 0);
        chk("ops", {16'd1384, 16'd256}, {16'(n_ops), 16'(n_rev)});
        chk("t5", 33'h0101fe00, {last_wr.length, last_wr.data,
            last_wr.incr, last_wr.check});
    endtask : sc_unit
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1;
        sc_misc();
        sc_self();
        sc_unit();
        stop_test();
    end
endmodule : testbench
